// File: bench/uart_flow_control_tb.sv
`timescale 1ns/1ps
module uart_flow_control_tb;
  import ufc_pkg::*;
  logic clk, rst, wr, rd, cts_n, dsr_n, rts_n, dtr_n, rxv, halt, resume, tx_en, ccv, ccr;
  logic [15:0] addr;
  logic [7:0] wdata, rd_data, rxc, cc, v;
  int fail_count = 0;
  int check_count = 0;
  int cycles = 0;
  ufc_flow_ctrl u_dut (.i_clk(clk), .i_sys_rst(rst), .i_addr(addr), .i_wr_data(wdata),
    .i_wr(wr), .i_rd(rd), .o_rd_data(rd_data), .i_cts_n(cts_n), .i_dsr_n(dsr_n),
    .o_rts_n(rts_n), .o_dtr_n(dtr_n), .i_rx_char_valid(rxv), .i_rx_char(rxc),
    .i_rx_halt_level(halt), .i_rx_resume_level(resume), .o_tx_enable(tx_en),
    .o_ctl_char_valid(ccv), .o_ctl_char(cc), .i_ctl_char_ready(ccr));
  ufc_remote u_remote (.i_clk(clk), .i_rts_n(rts_n), .i_dtr_n(dtr_n),
    .i_ctl_char_valid(ccv), .i_ctl_char(cc), .o_cts_n(cts_n), .o_dsr_n(dsr_n),
    .o_rx_char_valid(rxv), .o_rx_char(rxc), .o_ctl_char_ready(ccr));
  // 100 ns clock
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // hang guard
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      fail_count++;
      finish_test();
    end
  end
  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : finish_test
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp)
    begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : wait_cyc
  task automatic reg_wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask : reg_wr
  task automatic reg_rd(input logic [15:0] a, output logic [7:0] d);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    d = rd_data;
  endtask : reg_rd
  // reset values, access kinds, unmapped address
  task automatic t_reset();
    logic [15:0] a[6];
    logic [7:0] e[6];
    a = '{FLOW_MODE_ADDR, XON_CHAR_ADDR, XOFF_CHAR_ADDR, STATUS_ADDR,
      MODEM_LINE_CONTROL_ADDR, 16'hffa5};
    e = '{8'h00, XON_CHAR_RST, XOFF_CHAR_RST, 8'h01, MODEM_LINE_CONTROL_RST, 8'h00};
    chk({7'h00, tx_en}, 8'h01);
    chk({6'h00, dtr_n, rts_n}, 8'h00);
    for (int i = 0; i < 6; i++)
    begin
      reg_rd(a[i], v);
      chk(v, e[i]);
    end
    reg_wr(MODEM_LINE_CONTROL_ADDR, 8'ha5);
    reg_wr(STATUS_ADDR, 8'hff);
    reg_rd(MODEM_LINE_CONTROL_ADDR, v);
    chk(v, 8'ha5);
    reg_rd(STATUS_ADDR, v);
    chk(v, 8'h01);
    $display("test reset done");
  endtask : t_reset
  // both software bits together are dropped
  task automatic t_illegal();
    reg_wr(FLOW_MODE_ADDR, 8'h83);
    reg_rd(FLOW_MODE_ADDR, v);
    chk(v, 8'h00);
    reg_wr(FLOW_MODE_ADDR, 8'h0f);
    reg_rd(FLOW_MODE_ADDR, v);
    chk(v, 8'h0c);
    $display("test illegal done");
  endtask : t_illegal
  // Xoff, then an ordinary character, then Xon
  task automatic t_soft(input logic [7:0] m, input logic e_off, input logic e_any);
    reg_wr(FLOW_MODE_ADDR, m);
    u_remote.send_char(XOFF_CHAR_RST);
    wait_cyc(3);
    chk({7'h00, tx_en}, {7'h00, e_off});
    u_remote.send_char(8'h41);
    wait_cyc(3);
    chk({7'h00, tx_en}, {7'h00, e_any});
    u_remote.send_char(XON_CHAR_RST);
    wait_cyc(3);
    chk({7'h00, tx_en}, 8'h01);
    $display("test soft mode %h done", m);
  endtask : t_soft
  // handshake pins alone and combined with Xoff
  task automatic t_hw();
    reg_wr(FLOW_MODE_ADDR, 8'h05);
    u_remote.set_pins(1'b1, 1'b0);
    wait_cyc(5);
    chk({7'h00, tx_en}, 8'h00);
    reg_rd(STATUS_ADDR, v);
    chk(v, 8'h04);
    u_remote.send_char(XOFF_CHAR_RST);
    u_remote.set_pins(1'b0, 1'b0);
    wait_cyc(5);
    chk({7'h00, tx_en}, 8'h00);
    u_remote.send_char(XON_CHAR_RST);
    wait_cyc(3);
    chk({7'h00, tx_en}, 8'h01);
    reg_wr(FLOW_MODE_ADDR, 8'h08);
    u_remote.set_pins(1'b0, 1'b1);
    wait_cyc(5);
    chk({7'h00, tx_en}, 8'h00);
    u_remote.set_pins(1'b0, 1'b0);
    wait_cyc(5);
    chk({7'h00, tx_en}, 8'h01);
    $display("test handshake done");
  endtask : t_hw
  // programmed Xon character, then a reset in mid-run from a held state
  task automatic t_midrst();
    reg_wr(XON_CHAR_ADDR, 8'h5a);
    reg_wr(FLOW_MODE_ADDR, 8'h25);
    u_remote.send_char(XOFF_CHAR_RST);
    u_remote.send_char(XON_CHAR_RST);
    wait_cyc(3);
    chk({7'h00, tx_en}, 8'h00);
    u_remote.send_char(8'h5a);
    wait_cyc(3);
    chk({7'h00, tx_en}, 8'h01);
    u_remote.send_char(XOFF_CHAR_RST);
    halt <= 1'b1;
    wait_cyc(3);
    chk({7'h00, tx_en}, 8'h00);
    chk({6'h00, dtr_n, rts_n}, 8'h01);
    @(posedge clk);
    rst <= 1'b1;
    halt <= 1'b0;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    wait_cyc(1);
    chk({7'h00, tx_en}, 8'h01);
    chk({6'h00, dtr_n, rts_n}, 8'h00);
    reg_rd(FLOW_MODE_ADDR, v);
    chk(v, 8'h00);
    reg_rd(XON_CHAR_ADDR, v);
    chk(v, XON_CHAR_RST);
    $display("test mid-run reset done");
  endtask : t_midrst
  // every receive mode through one halt and one resume
  task automatic t_rx();
    int n0;
    for (int m = 0; m < 8; m++)
    begin
      u_remote.slow <= (m >= 4);
      reg_wr(FLOW_MODE_ADDR, 8'(m << 4));
      n0 = u_remote.n_taken;
      halt <= 1'b1;
      wait_cyc(4);
      halt <= 1'b0;
      chk({6'h00, dtr_n, rts_n}, 8'(m >> 1));
      chk(8'(u_remote.n_taken - n0), 8'(m & 1));
      if (m[0])
        chk(u_remote.last_taken, XOFF_CHAR_RST);
      resume <= 1'b1;
      wait_cyc(4);
      resume <= 1'b0;
      chk({6'h00, dtr_n, rts_n}, 8'h00);
      chk(8'(u_remote.n_taken - n0), 8'(2 * (m & 1)));
      if (m[0])
        chk(u_remote.last_taken, XON_CHAR_RST);
    end
    reg_wr(FLOW_MODE_ADDR, 8'h00);
    $display("test receive modes done");
  endtask : t_rx
  // main sequence
  initial
  begin
    rst = 1'b1;
    wr = 1'b0;
    rd = 1'b0;
    addr = 16'h0000;
    wdata = 8'h00;
    halt = 1'b0;
    resume = 1'b0;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    wait_cyc(3);
    t_reset();
    t_illegal();
    t_soft(8'h00, 1'b1, 1'b1);
    t_soft(8'h01, 1'b0, 1'b0);
    t_soft(8'h02, 1'b0, 1'b1);
    t_hw();
    t_midrst();
    t_rx();
    finish_test();
  end
endmodule : uart_flow_control_tb

// File: bench/ufc_remote.sv
`timescale 1ns/1ps
module ufc_remote (
  input wire logic i_clk,
  input wire logic i_rts_n,
  input wire logic i_dtr_n,
  input wire logic i_ctl_char_valid,
  input wire logic [7:0] i_ctl_char,
  output logic o_cts_n,
  output logic o_dsr_n,
  output logic o_rx_char_valid,
  output logic [7:0] o_rx_char,
  output logic o_ctl_char_ready
);
  logic slow = 1'b0;
  int n_taken = 0;
  logic [7:0] last_taken = 8'h00;
  // pins idle in the allow state
  initial
  begin
    o_cts_n = 1'b0;
    o_dsr_n = 1'b0;
    o_rx_char_valid = 1'b0;
    o_rx_char = 8'h00;
    o_ctl_char_ready = 1'b0;
  end
  // takes flow characters, stalling every other cycle when slow
  always @(posedge i_clk)
  begin
    o_ctl_char_ready <= slow ? ~o_ctl_char_ready : 1'b1;
    if (i_ctl_char_valid && o_ctl_char_ready)
    begin
      n_taken <= n_taken + 1;
      last_taken <= i_ctl_char;
    end
  end
  // one character, held off while the receiver asks us to stop
  task automatic send_char(input logic [7:0] c);
    @(posedge i_clk);
    while (i_rts_n || i_dtr_n) @(posedge i_clk);
    o_rx_char_valid <= 1'b1;
    o_rx_char <= c;
    @(posedge i_clk);
    o_rx_char_valid <= 1'b0;
    o_rx_char <= ~c; // released line does not keep the last value
  endtask : send_char
  // handshake lines, high asks the device to stop
  task automatic set_pins(input logic cts_n, input logic dsr_n);
    @(posedge i_clk);
    o_cts_n <= cts_n;
    o_dsr_n <= dsr_n;
  endtask : set_pins
endmodule : ufc_remote

// File: src/ufc_char_match.sv
`timescale 1ns/1ps
module ufc_char_match (
  input wire logic i_valid,
  input wire logic [ufc_pkg::DATA_W-1:0] i_char,
  input wire logic [ufc_pkg::DATA_W-1:0] i_xon_char,
  input wire logic [ufc_pkg::DATA_W-1:0] i_xoff_char,
  output logic o_is_xon,
  output logic o_is_xoff,
  output logic o_is_any
);
  import ufc_pkg::*;
  // classify one received character against the flow characters
  assign o_is_xon = i_valid && (i_char == i_xon_char);
  assign o_is_xoff = i_valid && (i_char == i_xoff_char);
  assign o_is_any = i_valid;
endmodule : ufc_char_match

// File: src/ufc_flow_ctrl.sv
`timescale 1ns/1ps
// Overview of operation
// - after any reset the transmitter starts in the Xon, allowed-to-send state
// - after any reset the flow mode is zero, no flow control applied
// - soft flow bit 0 alone: stop on Xoff, resume only on Xon
// - resume-on-any bit 1: stop on Xoff, resume on any received character other than Xoff
// - writing bits 0 and 1 together is illegal and clears both bits
// - bit 2 enables CTS, bit 3 DSR transmit handshake, combinable
// - bits 4, 5, 6 select Xon/Xoff, RTS, DTR receive control, all legal
// - RTS plus Xon/Xoff: RTS with Xoff on full, release with Xon on empty
// - combined modes stop on CTS or Xoff, resume needs both released
// - RTS and DTR enabled change together: driven full, released empty
// - RTS goes high at halt threshold, low again at resume threshold
module ufc_flow_ctrl (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  // register port
  input wire logic [ufc_pkg::ADDR_W-1:0] i_addr,
  input wire logic [ufc_pkg::DATA_W-1:0] i_wr_data,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [ufc_pkg::DATA_W-1:0] o_rd_data,
  // modem pins
  input wire logic i_cts_n,
  input wire logic i_dsr_n,
  output logic o_rts_n,
  output logic o_dtr_n,
  // received character stream
  input wire logic i_rx_char_valid,
  input wire logic [ufc_pkg::DATA_W-1:0] i_rx_char,
  // receiver fifo fill state
  input wire logic i_rx_halt_level,
  input wire logic i_rx_resume_level,
  // transmitter gate and flow character request
  output logic o_tx_enable,
  output logic o_ctl_char_valid,
  output logic [ufc_pkg::DATA_W-1:0] o_ctl_char,
  input wire logic i_ctl_char_ready
);
  import ufc_pkg::*;

  logic [FLOW_MODE_W-1:0] flow_mode_q;
  logic [DATA_W-1:0] modem_line_control_q;
  logic [DATA_W-1:0] xon_char_q;
  logic [DATA_W-1:0] xoff_char_q;
  logic [DATA_W-1:0] rd_data_q;
  logic [DATA_W-1:0] status;
  logic [FLOW_MODE_W-1:0] wr_mode;
  logic cts_n_s;
  logic dsr_n_s;
  logic is_xon;
  logic is_xoff;
  logic is_any;
  logic tx_soft_en;
  logic tx_any_en;
  logic cts_en;
  logic dsr_en;
  logic rx_soft_en;
  logic rts_en;
  logic dtr_en;
  logic rx_any_en;
  logic soft_hold_q;
  logic cts_hold;
  logic dsr_hold;
  logic tx_enable_q;
  logic rts_n_q;
  logic dtr_n_q;
  logic pend_q;
  logic [DATA_W-1:0] pend_char_q;
  logic go_halt;
  logic go_run;
  ufc_rx_state_t rx_state_q;
  ufc_rx_state_t rx_state_d;

  // pin synchronisers
  ufc_sync u_cts_sync (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_async(i_cts_n),
    .o_sync(cts_n_s)
  );
  ufc_sync u_dsr_sync (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_async(i_dsr_n),
    .o_sync(dsr_n_s)
  );

  // flow character detection
  ufc_char_match u_match (
    .i_valid(i_rx_char_valid),
    .i_char(i_rx_char),
    .i_xon_char(xon_char_q),
    .i_xoff_char(xoff_char_q),
    .o_is_xon(is_xon),
    .o_is_xoff(is_xoff),
    .o_is_any(is_any)
  );

  // mode field decode
  assign tx_soft_en = flow_mode_q[TX_SOFT_FLOW_EN_BIT];
  assign tx_any_en = flow_mode_q[TX_RESUME_ON_ANY_BIT];
  assign cts_en = flow_mode_q[TX_CTS_EN_BIT];
  assign dsr_en = flow_mode_q[TX_DSR_EN_BIT];
  assign rx_soft_en = flow_mode_q[RX_SOFT_FLOW_EN_BIT];
  assign rts_en = flow_mode_q[RX_RTS_EN_BIT];
  assign dtr_en = flow_mode_q[RX_DTR_EN_BIT];
  assign rx_any_en = rx_soft_en || rts_en || dtr_en;

  // written mode with the illegal software pair cleared
  always_comb
  begin
    wr_mode = i_wr_data[FLOW_MODE_W-1:0];
    if (wr_mode[TX_SOFT_FLOW_EN_BIT] && wr_mode[TX_RESUME_ON_ANY_BIT])
    begin
      wr_mode[TX_SOFT_FLOW_EN_BIT] = 1'b0;
      wr_mode[TX_RESUME_ON_ANY_BIT] = 1'b0;
    end
  end

  // flow mode register
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      flow_mode_q <= FLOW_MODE_RST;
    end
    else if (i_wr && i_addr == FLOW_MODE_ADDR)
    begin
      flow_mode_q <= wr_mode;
    end
  end

  // plain storage registers
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      modem_line_control_q <= MODEM_LINE_CONTROL_RST;
      xon_char_q <= XON_CHAR_RST;
      xoff_char_q <= XOFF_CHAR_RST;
    end
    else if (i_wr)
    begin
      if (i_addr == MODEM_LINE_CONTROL_ADDR)
      begin
        modem_line_control_q <= i_wr_data;
      end
      if (i_addr == XON_CHAR_ADDR)
      begin
        xon_char_q <= i_wr_data;
      end
      if (i_addr == XOFF_CHAR_ADDR)
      begin
        xoff_char_q <= i_wr_data;
      end
    end
  end

  // status word
  always_comb
  begin
    status = READ_ZERO;
    status[ST_TX_EN_BIT] = tx_enable_q;
    status[ST_SOFT_HOLD_BIT] = soft_hold_q;
    status[ST_CTS_HOLD_BIT] = cts_hold;
    status[ST_DSR_HOLD_BIT] = dsr_hold;
    status[ST_RX_HALT_BIT] = (rx_state_q == UFC_RX_HALT);
    status[ST_CHAR_PEND_BIT] = pend_q;
  end

  // read data one cycle after the strobe, zero elsewhere
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst || !i_rd)
    begin
      rd_data_q <= READ_ZERO;
    end
    else
    begin
      unique case (i_addr)
        FLOW_MODE_ADDR: rd_data_q <= {1'b0, flow_mode_q};
        XON_CHAR_ADDR: rd_data_q <= xon_char_q;
        XOFF_CHAR_ADDR: rd_data_q <= xoff_char_q;
        STATUS_ADDR: rd_data_q <= status;
        MODEM_LINE_CONTROL_ADDR: rd_data_q <= modem_line_control_q;
        default: rd_data_q <= READ_ZERO;
      endcase
    end
  end
  assign o_rd_data = rd_data_q;

  // software hold: set by Xoff, released by Xon or by any character other than Xoff
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      soft_hold_q <= 1'b0;
    end
    else if (!(tx_soft_en || tx_any_en))
    begin
      soft_hold_q <= 1'b0;
    end
    else if (is_xoff)
    begin
      soft_hold_q <= 1'b1;
    end
    else if ((tx_soft_en && is_xon) || (tx_any_en && is_any))
    begin
      soft_hold_q <= 1'b0;
    end
  end

  // hardware holds from the modem inputs, pin high means stop
  assign cts_hold = cts_en && cts_n_s;
  assign dsr_hold = dsr_en && dsr_n_s;

  // transmitter gate: any hold stops, all must clear to resume
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      tx_enable_q <= 1'b1;
    end
    else
    begin
      tx_enable_q <= !(soft_hold_q || cts_hold || dsr_hold);
    end
  end
  assign o_tx_enable = tx_enable_q;

  // receive halt decisions
  assign go_halt = rx_any_en && i_rx_halt_level;
  assign go_run = i_rx_resume_level || !rx_any_en;

  // receive handshake state machine
  always_comb
  begin
    rx_state_d = rx_state_q;
    unique case (rx_state_q)
      UFC_RX_RUN:
      begin
        if (go_halt)
        begin
          rx_state_d = UFC_RX_HALT;
        end
      end
      UFC_RX_HALT:
      begin
        if (go_run)
        begin
          rx_state_d = UFC_RX_RUN;
        end
      end
      default: rx_state_d = UFC_RX_RUN;
    endcase
  end

  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      rx_state_q <= UFC_RX_RUN;
    end
    else
    begin
      rx_state_q <= rx_state_d;
    end
  end

  // handshake pins follow the halt state together
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      rts_n_q <= 1'b0;
      dtr_n_q <= 1'b0;
    end
    else
    begin
      rts_n_q <= rts_en && (rx_state_d == UFC_RX_HALT);
      dtr_n_q <= dtr_en && (rx_state_d == UFC_RX_HALT);
    end
  end
  assign o_rts_n = rts_n_q;
  assign o_dtr_n = dtr_n_q;

  // flow character request, a newer event replaces a waiting one
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      pend_q <= 1'b0;
      pend_char_q <= XON_CHAR_RST;
    end
    else if (rx_soft_en && rx_state_q == UFC_RX_RUN && go_halt)
    begin
      pend_q <= 1'b1;
      pend_char_q <= xoff_char_q;
    end
    else if (rx_soft_en && rx_state_q == UFC_RX_HALT && go_run)
    begin
      pend_q <= 1'b1;
      pend_char_q <= xon_char_q;
    end
    else if (pend_q && i_ctl_char_ready)
    begin
      pend_q <= 1'b0;
    end
  end
  assign o_ctl_char_valid = pend_q;
  assign o_ctl_char = pend_char_q;

  // checks
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_sys_rst);

  AST_RESET_XON: assert property (
    $past(i_sys_rst) |-> o_tx_enable && !soft_hold_q)
    else $error("transmitter not in Xon after reset");
  AST_RESET_MODE0: assert property (
    $past(i_sys_rst) |-> flow_mode_q == FLOW_MODE_RST && !o_rts_n && !o_dtr_n)
    else $error("flow mode not zero after reset");
  AST_SOFT_STOP: assert property (
    (tx_soft_en && !tx_any_en && is_xoff && !(i_wr && i_addr == FLOW_MODE_ADDR))
    |=> soft_hold_q ##1 !o_tx_enable)
    else $error("Xoff did not stop transmitter");
  AST_SOFT_NO_ANY: assert property (
    (tx_soft_en && soft_hold_q && i_rx_char_valid && !is_xon
     && !(i_wr && i_addr == FLOW_MODE_ADDR)) |=> soft_hold_q)
    else $error("non-Xon character resumed transmitter");
  AST_ANY_RESUME: assert property (
    (tx_any_en && soft_hold_q && is_any && !is_xoff
     && !(i_wr && i_addr == FLOW_MODE_ADDR)) |=> !soft_hold_q)
    else $error("any character did not resume transmitter");
  AST_ILLEGAL_PAIR: assert property (
    (i_wr && i_addr == FLOW_MODE_ADDR && i_wr_data[1:0] == 2'b11)
    |=> flow_mode_q[1:0] == 2'b00 && flow_mode_q[6:2] == $past(i_wr_data[6:2]))
    else $error("illegal software pair kept");
  AST_CTS_STOP: assert property (
    (cts_hold && $stable(flow_mode_q)) |=> !o_tx_enable)
    else $error("CTS hold did not stop transmitter");
  AST_RX_MODES: assert property (
    (i_wr && i_addr == FLOW_MODE_ADDR) |=> flow_mode_q[6:4] == $past(i_wr_data[6:4]))
    else $error("receive mode bits not stored");
  AST_XOFF_WITH_RTS: assert property (
    (rx_soft_en && rts_en && rx_state_q == UFC_RX_RUN && i_rx_halt_level)
    |=> o_rts_n && o_ctl_char_valid && o_ctl_char == xoff_char_q)
    else $error("RTS and Xoff not issued together");
  AST_RESUME_BOTH: assert property (
    (soft_hold_q && cts_hold) ##1 (!cts_hold && soft_hold_q) |=> !o_tx_enable)
    else $error("resumed before both holds released");
  AST_PINS_TOGETHER: assert property (
    (rts_en && dtr_en && $stable(flow_mode_q)) |=> o_rts_n == o_dtr_n)
    else $error("RTS and DTR differ");
  AST_RTS_RELEASE: assert property (
    (rts_en && rx_state_q == UFC_RX_HALT && i_rx_resume_level) |=> !o_rts_n)
    else $error("RTS not released at resume level");

  COV_XOFF_XON: cover property (soft_hold_q ##[1:20] !soft_hold_q);
  COV_RX_HALT: cover property (rx_state_q == UFC_RX_HALT ##[1:20] rx_state_q == UFC_RX_RUN);
  COV_CTS_STOP: cover property (cts_hold ##1 !o_tx_enable);
  COV_CHAR_SENT: cover property (o_ctl_char_valid && i_ctl_char_ready);

endmodule : ufc_flow_ctrl

// File: src/ufc_pkg.sv
package ufc_pkg;
  // register bus widths
  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;
  // register byte addresses
  localparam logic [15:0] FLOW_MODE_ADDR = 16'hffa0;
  localparam logic [15:0] XON_CHAR_ADDR = 16'hffa1;
  localparam logic [15:0] XOFF_CHAR_ADDR = 16'hffa2;
  localparam logic [15:0] STATUS_ADDR = 16'hffa3;
  localparam logic [15:0] MODEM_LINE_CONTROL_ADDR = 16'hffa4;
  // flow mode field positions
  localparam int TX_SOFT_FLOW_EN_BIT = 0;
  localparam int TX_RESUME_ON_ANY_BIT = 1;
  localparam int TX_CTS_EN_BIT = 2;
  localparam int TX_DSR_EN_BIT = 3;
  localparam int RX_SOFT_FLOW_EN_BIT = 4;
  localparam int RX_RTS_EN_BIT = 5;
  localparam int RX_DTR_EN_BIT = 6;
  localparam int FLOW_MODE_W = 7;
  // status field positions
  localparam int ST_TX_EN_BIT = 0;
  localparam int ST_SOFT_HOLD_BIT = 1;
  localparam int ST_CTS_HOLD_BIT = 2;
  localparam int ST_DSR_HOLD_BIT = 3;
  localparam int ST_RX_HALT_BIT = 4;
  localparam int ST_CHAR_PEND_BIT = 5;
  // reset values
  localparam logic [6:0] FLOW_MODE_RST = 7'h00;
  localparam logic [7:0] MODEM_LINE_CONTROL_RST = 8'h00;
  localparam logic [7:0] XON_CHAR_RST = 8'h11;
  localparam logic [7:0] XOFF_CHAR_RST = 8'h13;
  localparam logic [7:0] READ_ZERO = 8'h00;
  // synchroniser depth for pins
  localparam int SYNC_STAGES = 2;
  // receive handshake state
  typedef enum logic [1:0] {
    UFC_RX_RUN = 2'b01,
    UFC_RX_HALT = 2'b10
  } ufc_rx_state_t;
endpackage : ufc_pkg

// File: src/ufc_sync.sv
`timescale 1ns/1ps
module ufc_sync (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_async,
  output logic o_sync
);
  import ufc_pkg::*;
  logic [SYNC_STAGES-1:0] stage_q;
  // two-flop synchroniser, pins idle high so reset to one
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      stage_q <= '1;
    end
    else
    begin
      stage_q <= {stage_q[SYNC_STAGES-2:0], i_async};
    end
  end
  assign o_sync = stage_q[SYNC_STAGES-1];
endmodule : ufc_sync
